// [hdl/sdram_cmd_pkg.sv]
// Package for the synchronous DRAM command decoder and its controller end.
// Assumes a single clock shared by both ends and a synchronous reset.
`default_nettype none

package sdram_cmd_pkg;

    // ********************************************
    // Command encodings {cs_n, ras_n, cas_n, we_n}
    // ********************************************
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_MODE_SET = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam logic [3:0] CMD_DESELECT = 4'hF;

    // ********************************************
    // Geometry and timing
    // ********************************************
    localparam int BANKS = 4;
    localparam int DATA_W = 16;
    localparam int BURST_W = 9;
    localparam logic [BURST_W-1:0] FULL_PAGE_CODE = 9'h000;
    localparam int CLOCK_NS = 40;
    localparam int RSC_NS = 15;
    // Least time rounds up, never below one cycle
    localparam int RSC_CYCLES = (RSC_NS + CLOCK_NS - 1) / CLOCK_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_BURST,
        ST_POWER_DOWN,
        ST_SUSPEND,
        ST_SELF_REFRESH
    } dev_state_type;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ACTIVATE,
        OP_READ,
        OP_WRITE,
        OP_PRECHARGE,
        OP_MODE_SET,
        OP_REFRESH,
        OP_BURST_STOP
    } op_type;

endpackage : sdram_cmd_pkg

`default_nettype wire

// [hdl/sdram_link_if.sv]
// Interface joining the controller end and the memory decoder end.
// Assumes the testbench resolves the shared data wire from the enables.
`default_nettype none

interface sdram_link_if;
    import sdram_cmd_pkg::*;
    logic chip_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
    logic clock_gate_in;
    logic bank_sel_lsb;
    logic bank_sel_msb;
    logic precharge_scope_bit;
    logic [1:0] byte_mask;
    logic [DATA_W-1:0] dq_ctrl_out;
    logic [DATA_W-1:0] dq_ctrl_oe;
    logic [DATA_W-1:0] dq_mem_out;
    logic [DATA_W-1:0] dq_mem_oe;
    logic [DATA_W-1:0] dq_in;

    modport controller (
        output chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
        output clock_gate_in, bank_sel_lsb, bank_sel_msb, precharge_scope_bit,
        output byte_mask, dq_ctrl_out, dq_ctrl_oe,
        input dq_in
    );
    modport memory (
        input chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
        input clock_gate_in, bank_sel_lsb, bank_sel_msb, precharge_scope_bit,
        input byte_mask, dq_in,
        output dq_mem_out, dq_mem_oe
    );
endinterface : sdram_link_if

`default_nettype wire

// [hdl/sdram_command_decoder.sv]
// Memory end: command decoder and power-state logic of a four-bank DRAM.
// Assumes link inputs are synchronous to clock_i; one data word per bank.
//
// Behaviour
// - Decode inputs only on rising clock edge
// - Decode command strobes when enable was high
// - Bank selects target; scope bit means all/auto
// - Accept commands only if previous enable high
// - Enable falls outside burst: power-down; with refresh in idle, self-refresh
// - Controller keeps enable high in burst while in_burst_i is set
// - Enable falls in burst: suspend, freeze burst
// - Power-down exits on rising enable with nop
// - Suspend exits on rising enable; burst resumes
// - Burst stop ends any burst; controller drops it unless full_page_i
// - Controller waits after mode set
`default_nettype none

module sdram_command_decoder
    import sdram_cmd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    sdram_link_if.memory link,
    output logic [2:0] state_o,
    output logic [BANKS-1:0] bank_open_o,
    output logic [BURST_W-1:0] burst_len_o,
    output logic refresh_pulse_o
);

    // ********************************************
    // State
    // ********************************************
    dev_state_type state_r, state_nxt;
    logic cke_prev_r, cke_prev_nxt;
    logic [BANKS-1:0] open_r, open_nxt;
    logic [BURST_W-1:0] blen_r, blen_nxt;
    logic [BURST_W-1:0] bcount_r, bcount_nxt;
    logic bwrite_r, bwrite_nxt;
    logic bauto_r, bauto_nxt;
    logic [1:0] bbank_r, bbank_nxt;
    logic [DATA_W-1:0] mem_r [BANKS];
    logic [DATA_W-1:0] mem_nxt [BANKS];
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic [DATA_W-1:0] doe_r, doe_nxt;
    logic refresh_r, refresh_nxt;

    logic [3:0] cmd;
    logic [1:0] bank;
    logic idle_cmd;
    logic [BURST_W-1:0] remain;

    assign cmd = {link.chip_select_n, link.row_strobe_n, link.col_strobe_n,
                  link.write_enable_n};
    assign bank = {link.bank_sel_msb, link.bank_sel_lsb};
    // Deselect, no-op or burst stop (ras_n and cas_n high)
    assign idle_cmd = link.chip_select_n || (cmd[2:1] == 2'b11);
    assign remain = bcount_r - 9'h001;

    // ********************************************
    // Next-state logic
    // ********************************************
    always_comb begin
        state_nxt = state_r;
        cke_prev_nxt = link.clock_gate_in;
        open_nxt = open_r;
        blen_nxt = blen_r;
        bcount_nxt = bcount_r;
        bwrite_nxt = bwrite_r;
        bauto_nxt = bauto_r;
        bbank_nxt = bbank_r;
        mem_nxt = mem_r;
        dout_nxt = dout_r;
        doe_nxt = '0;
        refresh_nxt = 1'b0;
        unique case (state_r)
            ST_POWER_DOWN: begin
                // Exit needs deselect, nop or burst stop on the rising edge
                if (!cke_prev_r && link.clock_gate_in && idle_cmd) begin
                    state_nxt = (open_r != '0) ? ST_ACTIVE : ST_IDLE;
                end
            end
            ST_SELF_REFRESH: begin
                if (!cke_prev_r && link.clock_gate_in && idle_cmd) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_SUSPEND: begin
                // Burst counter is frozen here
                if (!cke_prev_r && link.clock_gate_in) begin
                    state_nxt = ST_BURST;
                end
            end
            default: begin
                if (cke_prev_r) begin
                    if (!link.clock_gate_in && state_r == ST_BURST) begin
                        state_nxt = ST_SUSPEND;
                    end else if (!link.clock_gate_in && idle_cmd) begin
                        state_nxt = ST_POWER_DOWN;
                    end else begin
                        // Burst progress for this cycle
                        if (state_r == ST_BURST) begin
                            if (bwrite_r && !link.byte_mask[0]) begin
                                mem_nxt[bbank_r] = link.dq_in;
                            end
                            if (!bwrite_r) begin
                                dout_nxt = mem_r[bbank_r];
                                doe_nxt = {{8{!link.byte_mask[1]}},
                                           {8{!link.byte_mask[0]}}};
                            end
                            if (blen_r != FULL_PAGE_CODE) begin
                                bcount_nxt = remain;
                                if (remain == '0) begin
                                    state_nxt = ST_ACTIVE;
                                    if (bauto_r) begin
                                        open_nxt[bbank_r] = 1'b0;
                                        state_nxt = (open_nxt != '0) ? ST_ACTIVE : ST_IDLE;
                                    end
                                end
                            end
                        end
                        unique case (cmd)
                            CMD_ACTIVATE: begin
                                open_nxt[bank] = 1'b1;
                                state_nxt = ST_ACTIVE;
                            end
                            CMD_PRECHARGE: begin
                                if (link.precharge_scope_bit) begin
                                    open_nxt = '0;
                                end else begin
                                    open_nxt[bank] = 1'b0;
                                end
                                state_nxt = (open_nxt != '0) ? ST_ACTIVE : ST_IDLE;
                            end
                            CMD_READ, CMD_WRITE: begin
                                if (open_r[bank]) begin
                                    bwrite_nxt = !link.write_enable_n;
                                    bauto_nxt = link.precharge_scope_bit;
                                    bbank_nxt = bank;
                                    bcount_nxt = blen_r;
                                    state_nxt = ST_BURST;
                                    if (!link.write_enable_n && !link.byte_mask[0]) begin
                                        mem_nxt[bank] = link.dq_in;
                                    end
                                end
                            end
                            CMD_MODE_SET: begin
                                if (state_r == ST_IDLE) begin
                                    blen_nxt = link.dq_in[BURST_W-1:0];
                                end
                            end
                            CMD_REFRESH: begin
                                if (state_r == ST_IDLE) begin
                                    if (link.clock_gate_in) begin
                                        refresh_nxt = 1'b1;
                                    end else begin
                                        state_nxt = ST_SELF_REFRESH;
                                    end
                                end
                            end
                            CMD_BURST_STOP: begin
                                if (state_r == ST_BURST) begin
                                    state_nxt = ST_ACTIVE;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // ********************************************
    // Registers
    // ********************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cke_prev_r <= 1'b0;
            open_r <= '0;
            blen_r <= 9'h001;
            bcount_r <= '0;
            bwrite_r <= 1'b0;
            bauto_r <= 1'b0;
            bbank_r <= 2'h0;
            for (int i = 0; i < BANKS; i++) begin
                mem_r[i] <= '0;
            end
            dout_r <= '0;
            doe_r <= '0;
            refresh_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cke_prev_r <= cke_prev_nxt;
            open_r <= open_nxt;
            blen_r <= blen_nxt;
            bcount_r <= bcount_nxt;
            bwrite_r <= bwrite_nxt;
            bauto_r <= bauto_nxt;
            bbank_r <= bbank_nxt;
            mem_r <= mem_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            refresh_r <= refresh_nxt;
        end
    end

    assign link.dq_mem_out = dout_r;
    assign link.dq_mem_oe = doe_r;
    assign state_o = state_r;
    assign bank_open_o = open_r;
    assign burst_len_o = blen_r;
    assign refresh_pulse_o = refresh_r;

endmodule : sdram_command_decoder

`default_nettype wire

// [hdl/sdram_controller_end.sv]
// Controller end: issues one command per request and keeps link rules.
// Assumes user requests are synchronous; busy_o stalls new requests.
`default_nettype none

module sdram_controller_end
    import sdram_cmd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    sdram_link_if.controller link,
    input wire logic req_i,
    input wire logic [3:0] req_cmd_i,
    input wire logic [1:0] req_bank_i,
    input wire logic req_scope_i,
    input wire logic [1:0] req_mask_i,
    input wire logic [DATA_W-1:0] req_data_i,
    input wire logic gate_i,
    input wire logic full_page_i,
    input wire logic in_burst_i,
    output logic busy_o
);

    logic [3:0] cmd_r, cmd_nxt;
    logic cke_r, cke_nxt;
    logic [1:0] bank_r, bank_nxt;
    logic scope_r, scope_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic [DATA_W-1:0] oe_r, oe_nxt;
    logic [3:0] wait_r, wait_nxt;
    logic busy_r, busy_nxt;
    logic legal;

    // Burst stop outside full page is dropped
    assign legal = !(req_cmd_i == CMD_BURST_STOP && !full_page_i);

    always_comb begin
        cmd_nxt = CMD_NOP;
        bank_nxt = bank_r;
        scope_nxt = scope_r;
        mask_nxt = req_mask_i;
        data_nxt = req_data_i;
        oe_nxt = '0;
        wait_nxt = (wait_r != 4'h0) ? wait_r - 4'h1 : 4'h0;
        // Never drop the gate while in_burst_i is set
        cke_nxt = gate_i || in_burst_i;
        // Raising the gate always goes out with a no-op
        // Refresh with the gate dropping asks for self-refresh
        if (req_i && wait_r == 4'h0 && cke_r && (gate_i || req_cmd_i == CMD_REFRESH)
                && legal) begin
            cmd_nxt = req_cmd_i;
            bank_nxt = req_bank_i;
            scope_nxt = req_scope_i;
            // Mode word rides on the data lines as well
            if (req_cmd_i == CMD_WRITE || req_cmd_i == CMD_MODE_SET) begin
                oe_nxt = '1;
            end
            if (req_cmd_i == CMD_MODE_SET) begin
                wait_nxt = 4'(RSC_CYCLES);
            end
        end
        busy_nxt = (wait_nxt != 4'h0) || !cke_nxt;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cmd_r <= CMD_NOP;
            cke_r <= 1'b1;
            bank_r <= 2'h0;
            scope_r <= 1'b0;
            mask_r <= 2'h3;
            data_r <= '0;
            oe_r <= '0;
            wait_r <= 4'h0;
            busy_r <= 1'b1;
        end else begin
            cmd_r <= cmd_nxt;
            cke_r <= cke_nxt;
            bank_r <= bank_nxt;
            scope_r <= scope_nxt;
            mask_r <= mask_nxt;
            data_r <= data_nxt;
            oe_r <= oe_nxt;
            wait_r <= wait_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign {link.chip_select_n, link.row_strobe_n, link.col_strobe_n,
            link.write_enable_n} = cmd_r;
    assign link.clock_gate_in = cke_r;
    assign {link.bank_sel_msb, link.bank_sel_lsb} = bank_r;
    assign link.precharge_scope_bit = scope_r;
    assign link.byte_mask = mask_r;
    assign link.dq_ctrl_out = data_r;
    assign link.dq_ctrl_oe = oe_r;
    assign busy_o = busy_r;

endmodule : sdram_controller_end

`default_nettype wire

// [verification/sdram_link_assertions.sv]
// Checker on the link that joins the controller end to the decoder end.
// Assumes one clock domain; instantiated beside the interface, no bind.
`default_nettype none

module sdram_link_assertions
    import sdram_cmd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_enable_n,
    input wire logic clock_gate_in,
    input wire logic [1:0] byte_mask,
    input wire logic [DATA_W-1:0] dq_ctrl_oe,
    input wire logic [DATA_W-1:0] dq_mem_oe,
    input wire logic [DATA_W-1:0] dq_in
);
    // ****************
    // Helper logic
    // ****************
    logic [3:0] cmd;
    logic quiet;
    logic full_page_r;
    logic full_page_nxt;
    assign cmd = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
    assign quiet = chip_select_n || (cmd == CMD_NOP);
    // The last mode word decides whether burst stop is legal
    always_comb begin
        full_page_nxt = full_page_r;
        if (cmd == CMD_MODE_SET) begin
            full_page_nxt = (dq_in[BURST_W-1:0] == FULL_PAGE_CODE);
        end
    end
    always_ff @(posedge clock_i) begin
        full_page_r <= rst_i ? 1'b0 : full_page_nxt;
    end

    // ****************
    // Properties
    // ****************
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    cmd_gate_a: assert property (!quiet |-> $past(clock_gate_in))
        else $error("command while enable was low");
    low_quiet_a: assert property (!clock_gate_in && !$past(clock_gate_in) |-> quiet)
        else $error("command while enable held low");
    pd_entry_a: assert property ($fell(clock_gate_in) |-> quiet || cmd == CMD_REFRESH)
        else $error("enable fell with a command");
    pd_exit_a: assert property ($rose(clock_gate_in) |-> quiet)
        else $error("enable rose with a command");
    mode_gap_a: assert property (cmd == CMD_MODE_SET |-> ##1 quiet)
        else $error("command too soon after mode set");
    stop_page_a: assert property (cmd == CMD_BURST_STOP |-> full_page_r)
        else $error("burst stop outside full page");
    no_fight_a: assert property ((dq_ctrl_oe & dq_mem_oe) == 16'h0000)
        else $error("both ends drive data");
    mask_float_a: assert property
        (byte_mask == 2'h3 && $past(byte_mask) == 2'h3 |-> dq_mem_oe == 16'h0000)
        else $error("masked read drives data");
    wr_drive_a: assert property (cmd == CMD_WRITE |-> dq_ctrl_oe == 16'hFFFF)
        else $error("write without data driven");

    cover property (cmd == CMD_MODE_SET);
    cover property ($fell(clock_gate_in));
    cover property (cmd == CMD_BURST_STOP);
    cover property (dq_mem_oe != 16'h0000);
    cover property (cmd == CMD_REFRESH && !clock_gate_in);
endmodule : sdram_link_assertions

`default_nettype wire

// [verification/tb_top.sv]
// Testbench driving the controller end's user side against the decoder end.
// Assumes both ends share one 25 MHz clock and a synchronous reset.
`default_nettype none

module tb_top
    import sdram_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_i = 1'b0;
    logic [3:0] req_cmd_i = CMD_NOP;
    logic [1:0] req_bank_i = 2'h0;
    logic req_scope_i = 1'b0;
    logic [1:0] req_mask_i = 2'h3;
    logic [DATA_W-1:0] req_data_i = 16'h0000;
    logic gate_i = 1'b1;
    logic full_page_i = 1'b0;
    logic in_burst_i = 1'b0;
    logic busy_o;
    logic [2:0] state_o;
    logic [BANKS-1:0] bank_open_o;
    logic [BURST_W-1:0] burst_len_o;
    logic refresh_pulse_o;
    logic [DATA_W-1:0] float_r = 16'h5A5A;
    logic [DATA_W-1:0] rd;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int oe_cnt;
    int pulse_cnt;

    sdram_link_if sdram_link_if_i ();
    // Released bits toggle so a stale word never passes as read data
    assign sdram_link_if_i.dq_in = (sdram_link_if_i.dq_ctrl_out & sdram_link_if_i.dq_ctrl_oe)
        | (sdram_link_if_i.dq_mem_out & sdram_link_if_i.dq_mem_oe)
        | (float_r & ~(sdram_link_if_i.dq_ctrl_oe | sdram_link_if_i.dq_mem_oe));

    sdram_controller_end sdram_controller_end_i (.clock_i(clock_i), .rst_i(rst_i),
        .link(sdram_link_if_i), .req_i(req_i), .req_cmd_i(req_cmd_i), .req_bank_i(req_bank_i),
        .req_scope_i(req_scope_i), .req_mask_i(req_mask_i), .req_data_i(req_data_i),
        .gate_i(gate_i), .full_page_i(full_page_i), .in_burst_i(in_burst_i), .busy_o(busy_o));
    sdram_command_decoder sdram_command_decoder_i (.clock_i(clock_i), .rst_i(rst_i),
        .link(sdram_link_if_i), .state_o(state_o), .bank_open_o(bank_open_o),
        .burst_len_o(burst_len_o), .refresh_pulse_o(refresh_pulse_o));
    sdram_link_assertions sdram_link_assertions_i (.clock_i(clock_i), .rst_i(rst_i),
        .chip_select_n(sdram_link_if_i.chip_select_n),
        .row_strobe_n(sdram_link_if_i.row_strobe_n),
        .col_strobe_n(sdram_link_if_i.col_strobe_n),
        .write_enable_n(sdram_link_if_i.write_enable_n),
        .clock_gate_in(sdram_link_if_i.clock_gate_in), .byte_mask(sdram_link_if_i.byte_mask),
        .dq_ctrl_oe(sdram_link_if_i.dq_ctrl_oe), .dq_mem_oe(sdram_link_if_i.dq_mem_oe),
        .dq_in(sdram_link_if_i.dq_in));

    // ****************
    // Clock and tasks
    // ****************
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) float_r <= ~float_r;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wait_st(input dev_state_type exp);
        int k;
        k = 0;
        while (state_o !== exp && k < 12) begin
            @(negedge clock_i);
            k++;
        end
        chk("state", 16'(exp), 16'(state_o));
    endtask : wait_st

    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic s,
            input logic [1:0] m, input logic [15:0] d);
        int k;
        k = 0;
        @(negedge clock_i);
        while (busy_o !== 1'b0 && k < 20) begin
            @(negedge clock_i);
            k++;
        end
        req_cmd_i = c;
        req_bank_i = b;
        req_scope_i = s;
        req_mask_i = m;
        req_data_i = d;
        req_i = 1'b1;
        @(negedge clock_i);
        req_i = 1'b0;
    endtask : issue

    task automatic watch(input int n);
        oe_cnt = 0;
        pulse_cnt = 0;
        rd = 16'hXXXX;
        repeat (n) begin
            @(negedge clock_i);
            if (sdram_link_if_i.dq_mem_oe !== 16'h0000) begin
                if (oe_cnt == 0) begin
                    rd = sdram_link_if_i.dq_in;
                end
                oe_cnt++;
            end
            if (refresh_pulse_o === 1'b1) begin
                pulse_cnt++;
            end
        end
    endtask : watch

    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (16) @(negedge clock_i);
        rst_i = 1'b0;
        issue(CMD_MODE_SET, 2'h0, 1'b0, 2'h3, 16'h0008);
        repeat (2) @(negedge clock_i);
        chk("burst_len", 16'h0008, 16'(burst_len_o));
        issue(CMD_ACTIVATE, 2'h2, 1'b0, 2'h3, 16'h0000);
        wait_st(ST_ACTIVE);
        chk("bank_open", 16'h0004, 16'(bank_open_o));
        issue(CMD_WRITE, 2'h2, 1'b0, 2'h0, 16'hA5C3);
        // Only the command beat carries data; later beats are masked
        req_mask_i = 2'h3;
        wait_st(ST_BURST);
        gate_i = 1'b0;
        wait_st(ST_SUSPEND);
        repeat (3) @(negedge clock_i);
        wait_st(ST_SUSPEND);
        gate_i = 1'b1;
        wait_st(ST_BURST);
        wait_st(ST_ACTIVE);
        issue(CMD_READ, 2'h2, 1'b0, 2'h0, 16'h0000);
        watch(6);
        chk("read_data", 16'hA5C3, rd);
        wait_st(ST_ACTIVE);
        issue(CMD_WRITE, 2'h2, 1'b0, 2'h3, 16'h1234);
        wait_st(ST_BURST);
        wait_st(ST_ACTIVE);
        issue(CMD_READ, 2'h2, 1'b0, 2'h0, 16'h0000);
        watch(6);
        chk("masked_write", 16'hA5C3, rd);
        wait_st(ST_ACTIVE);
        issue(CMD_READ, 2'h2, 1'b0, 2'h3, 16'h0000);
        watch(10);
        chk("masked_oe", 16'h0000, 16'(oe_cnt));
        wait_st(ST_ACTIVE);
        in_burst_i = 1'b1;
        issue(CMD_READ, 2'h2, 1'b0, 2'h0, 16'h0000);
        wait_st(ST_BURST);
        gate_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk("gate", 16'h0001, 16'(sdram_link_if_i.clock_gate_in));
        gate_i = 1'b1;
        in_burst_i = 1'b0;
        wait_st(ST_ACTIVE);
        issue(CMD_ACTIVATE, 2'h0, 1'b0, 2'h3, 16'h0000);
        repeat (2) @(negedge clock_i);
        chk("bank_open", 16'h0005, 16'(bank_open_o));
        issue(CMD_PRECHARGE, 2'h0, 1'b1, 2'h3, 16'h0000);
        wait_st(ST_IDLE);
        chk("bank_open", 16'h0000, 16'(bank_open_o));
        issue(CMD_REFRESH, 2'h0, 1'b0, 2'h3, 16'h0000);
        watch(5);
        chk("refresh", 16'h0001, 16'(pulse_cnt));
        // Gate drops in the same cycle as the refresh request
        @(negedge clock_i);
        req_cmd_i = CMD_REFRESH;
        gate_i = 1'b0;
        req_i = 1'b1;
        @(negedge clock_i);
        req_i = 1'b0;
        wait_st(ST_SELF_REFRESH);
        gate_i = 1'b1;
        wait_st(ST_IDLE);
        gate_i = 1'b0;
        wait_st(ST_POWER_DOWN);
        gate_i = 1'b1;
        wait_st(ST_IDLE);
        full_page_i = 1'b1;
        issue(CMD_MODE_SET, 2'h0, 1'b0, 2'h3, 16'h0000);
        issue(CMD_ACTIVATE, 2'h1, 1'b0, 2'h3, 16'h0000);
        wait_st(ST_ACTIVE);
        issue(CMD_READ, 2'h1, 1'b0, 2'h3, 16'h0000);
        wait_st(ST_BURST);
        repeat (12) @(negedge clock_i);
        wait_st(ST_BURST);
        full_page_i = 1'b0;
        issue(CMD_BURST_STOP, 2'h1, 1'b0, 2'h3, 16'h0000);
        repeat (2) @(negedge clock_i);
        chk("stop_dropped", 16'(ST_BURST), 16'(state_o));
        full_page_i = 1'b1;
        issue(CMD_BURST_STOP, 2'h1, 1'b0, 2'h3, 16'h0000);
        wait_st(ST_ACTIVE);
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
